// ### nand_host_defines.vh
// timing counts, command codes and address layout for the nand host controller
`ifndef NAND_HOST_DEFINES_VH
`define NAND_HOST_DEFINES_VH
`define CLK_PERIOD_NS 8
`define T_STROBE_LOW_NS 25
`define T_STROBE_HIGH_NS 15
`define STROBE_LOW_CYC ((`T_STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC ((`T_STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_READ_LO 8'h00
`define CMD_READ_HI 8'h01
`define CMD_READ_SPARE 8'h50
`define CMD_READ_ID 8'h90
`define CMD_RESET 8'hFF
`define CMD_PROG_SETUP 8'h80
`define CMD_PROG_GO 8'h10
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_GO 8'hD0
`define CMD_STATUS 8'h70
`define OP_READ_LO 3'h0
`define OP_READ_HI 3'h1
`define OP_READ_SPARE 3'h2
`define OP_READ_ID 3'h3
`define OP_RESET 3'h4
`define OP_PROGRAM 3'h5
`define OP_ERASE 3'h6
`define OP_STATUS 3'h7
`define PAGE_BYTES 528
`define SPARE_FIRST 512
`define ADDR_ROW_LSB 9
`endif

// ### strobe_timer.v
// one pin strobe cycle: low phase then high phase, with a done pulse
`timescale 1ns/100ps
module strobe_timer #(
    parameter LOW_CYC = 4,
    parameter HIGH_CYC = 2
) (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // control
    input wire start,
    output reg strobe_n,
    output reg sample,
    output reg done
);
    reg [7:0] cnt_r;
    reg busy_r;
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
            strobe_n <= 1'b1;
            sample <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            sample <= 1'b0;
            done <= 1'b0;
            if (!busy_r)
            begin
                if (start)
                begin
                    busy_r <= 1'b1;
                    strobe_n <= 1'b0;
                    cnt_r <= 8'h00;
                end
            end
            else
            begin
                cnt_r <= cnt_r + 8'h01;
                if (cnt_r == LOW_CYC - 1)
                begin
                    // sample read data just before the rising edge
                    sample <= 1'b1;
                    strobe_n <= 1'b1;
                end
                if (cnt_r == LOW_CYC + HIGH_CYC - 1)
                begin
                    busy_r <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ### nand_host.v
// host-side sequencer driving a small-page nand flash through its pins
// Contract
// - host drops write strobe with chip select low; byte taken on rise
// - address cycles: column 0-7, row 9-16, row 17-23 with bit 7 low
// - page read and program take three address cycles in order
// - program: setup command, address, data, confirm command
// - erase: setup command, two row cycles, confirm command
// - host issues only defined command codes
`timescale 1ns/100ps
`include "nand_host_defines.vh"
module nand_host #(
    parameter ROW_BITS = 15,
    parameter COL_BITS = 10
) (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // user request
    input wire req_valid,
    input wire [2:0] req_op,
    input wire [ROW_BITS-1:0] req_row,
    input wire [7:0] req_col,
    input wire [COL_BITS-1:0] req_len,
    output reg req_ready,
    // write data
    input wire [7:0] wr_data,
    output reg wr_take,
    // read data
    output reg [7:0] rd_data,
    output reg rd_valid,
    output reg op_done,
    // flash pins
    output reg chip_select_n,
    output reg cmd_latch_sel,
    output reg addr_latch_sel,
    output reg write_strobe_n,
    output reg data_out_strobe_n,
    output reg program_lock_n,
    output reg spare_area_skip,
    input wire [7:0] io_in,
    output reg [7:0] io_out,
    output reg io_oe_n,
    input wire ready_busy_n
);
    // ************************************************
    // state machine
    // ************************************************
    localparam S_IDLE = 4'h0;
    localparam S_CMD = 4'h1;
    localparam S_ADDR = 4'h2;
    localparam S_WDATA = 4'h3;
    localparam S_CONF = 4'h4;
    localparam S_WAIT = 4'h5;
    localparam S_RDATA = 4'h6;
    localparam S_GAP = 4'h7;

    reg [3:0] state_r;
    reg [2:0] op_r;
    reg [7:0] addr_r [0:2];
    reg [1:0] acnt_r;
    reg [1:0] alast_r;
    reg [COL_BITS-1:0] len_r;
    reg wstart_r;
    reg rstart_r;
    reg [1:0] gap_r;
    reg rb_s1_r;
    reg rb_r;
    wire w_strobe;
    wire w_done;
    wire r_strobe;
    wire r_sample;
    wire r_done;
    reg [7:0] cmd_code;

    // write-side strobe
    strobe_timer #(.LOW_CYC(`STROBE_LOW_CYC), .HIGH_CYC(`STROBE_HIGH_CYC)) u_wr (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(wstart_r),
        .strobe_n(w_strobe),
        .sample(),
        .done(w_done)
    );
    // read-side strobe
    strobe_timer #(.LOW_CYC(`STROBE_LOW_CYC), .HIGH_CYC(`STROBE_HIGH_CYC)) u_rd (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(rstart_r),
        .strobe_n(r_strobe),
        .sample(r_sample),
        .done(r_done)
    );

    always @*
    begin
        case (op_r)
            `OP_READ_LO: cmd_code = `CMD_READ_LO;
            `OP_READ_HI: cmd_code = `CMD_READ_HI;
            `OP_READ_SPARE: cmd_code = `CMD_READ_SPARE;
            `OP_READ_ID: cmd_code = `CMD_READ_ID;
            `OP_RESET: cmd_code = `CMD_RESET;
            `OP_PROGRAM: cmd_code = `CMD_PROG_SETUP;
            `OP_ERASE: cmd_code = `CMD_ERASE_SETUP;
            default: cmd_code = `CMD_STATUS;
        endcase
    end

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= S_IDLE;
            op_r <= 3'h0;
            addr_r[0] <= 8'h00;
            addr_r[1] <= 8'h00;
            addr_r[2] <= 8'h00;
            acnt_r <= 2'h0;
            alast_r <= 2'h0;
            len_r <= {COL_BITS{1'b0}};
            wstart_r <= 1'b0;
            rstart_r <= 1'b0;
            gap_r <= 2'h0;
            // busy until the pin is seen: a request right after reset must not slip in
            rb_s1_r <= 1'b0;
            rb_r <= 1'b0;
            req_ready <= 1'b0;
            wr_take <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            op_done <= 1'b0;
            chip_select_n <= 1'b1;
            cmd_latch_sel <= 1'b0;
            addr_latch_sel <= 1'b0;
            write_strobe_n <= 1'b1;
            data_out_strobe_n <= 1'b1;
            program_lock_n <= 1'b0;
            spare_area_skip <= 1'b1;
            io_out <= 8'h00;
            io_oe_n <= 1'b1;
        end
        else
        begin
            rb_s1_r <= ready_busy_n;
            rb_r <= rb_s1_r;
            wstart_r <= 1'b0;
            rstart_r <= 1'b0;
            wr_take <= 1'b0;
            rd_valid <= 1'b0;
            op_done <= 1'b0;
            write_strobe_n <= w_strobe;
            data_out_strobe_n <= r_strobe;
            // spare included only for the spare read
            spare_area_skip <= (op_r != `OP_READ_SPARE);
            case (state_r)
                S_IDLE:
                begin
                    req_ready <= 1'b1;
                    cmd_latch_sel <= 1'b0;
                    addr_latch_sel <= 1'b0;
                    io_oe_n <= 1'b1;
                    chip_select_n <= 1'b1;
                    // wait for ready before new commands
                    if (req_valid && req_ready && rb_r)
                    begin
                        req_ready <= 1'b0;
                        op_r <= req_op;
                        // column, row low, row high with bit 7 low
                        addr_r[0] <= req_col;
                        addr_r[1] <= req_row[7:0];
                        addr_r[2] <= {1'b0, req_row[14:8]};
                        len_r <= req_len;
                        // lift the lock only for program and erase
                        program_lock_n <= (req_op == `OP_PROGRAM) || (req_op == `OP_ERASE);
                        chip_select_n <= 1'b0;
                        cmd_latch_sel <= 1'b1;
                        state_r <= S_CMD;
                        wstart_r <= 1'b1;
                    end
                end
                S_CMD:
                begin
                    // command byte with command latch high
                    io_out <= cmd_code;
                    io_oe_n <= 1'b0;
                    if (w_done)
                    begin
                        cmd_latch_sel <= 1'b0;
                        acnt_r <= (op_r == `OP_ERASE) ? 2'h1 : 2'h0;
                        // last index 2: three cycles, two for erase which starts at 1; id read takes one
                        alast_r <= (op_r == `OP_READ_ID) ? 2'h0 : 2'h2;
                        if (op_r == `OP_RESET || op_r == `OP_STATUS)
                            state_r <= (op_r == `OP_STATUS) ? S_RDATA : S_WAIT;
                        else
                        begin
                            addr_latch_sel <= 1'b1;
                            wstart_r <= 1'b1;
                            state_r <= S_ADDR;
                        end
                        if (op_r == `OP_STATUS)
                        begin
                            io_oe_n <= 1'b1;
                            len_r <= {{(COL_BITS-1){1'b0}}, 1'b1};
                            gap_r <= 2'h3;
                        end
                    end
                end
                S_ADDR:
                begin
                    // address bytes with address latch high
                    io_out <= addr_r[acnt_r];
                    if (w_done)
                    begin
                        if (acnt_r == alast_r)
                        begin
                            addr_latch_sel <= 1'b0;
                            if (op_r == `OP_PROGRAM)
                            begin
                                state_r <= S_WDATA;
                                wr_take <= 1'b1;
                                io_out <= wr_data;
                                wstart_r <= 1'b1;
                            end
                            else if (op_r == `OP_ERASE)
                            begin
                                cmd_latch_sel <= 1'b1;
                                io_out <= `CMD_ERASE_GO;
                                wstart_r <= 1'b1;
                                state_r <= S_CONF;
                            end
                            else
                                state_r <= S_WAIT;
                        end
                        else
                        begin
                            acnt_r <= acnt_r + 2'h1;
                            wstart_r <= 1'b1;
                        end
                    end
                end
                S_WDATA:
                begin
                    if (w_done)
                    begin
                        len_r <= len_r - {{(COL_BITS-1){1'b0}}, 1'b1};
                        wstart_r <= 1'b1;
                        if (len_r == {{(COL_BITS-1){1'b0}}, 1'b1})
                        begin
                            cmd_latch_sel <= 1'b1;
                            io_out <= `CMD_PROG_GO;
                            state_r <= S_CONF;
                        end
                        else
                        begin
                            wr_take <= 1'b1;
                            io_out <= wr_data;
                        end
                    end
                end
                S_CONF:
                begin
                    if (w_done)
                    begin
                        cmd_latch_sel <= 1'b0;
                        io_oe_n <= 1'b1;
                        gap_r <= 2'h3;
                        state_r <= S_WAIT;
                    end
                end
                S_WAIT:
                begin
                    // busy flag settles before we trust ready
                    io_oe_n <= 1'b1;
                    if (gap_r != 2'h0)
                        gap_r <= gap_r - 2'h1;
                    else if (rb_r)
                    begin
                        if (op_r == `OP_PROGRAM || op_r == `OP_ERASE || op_r == `OP_RESET)
                        begin
                            program_lock_n <= 1'b0;
                            op_done <= 1'b1;
                            state_r <= S_IDLE;
                        end
                        else
                            state_r <= S_RDATA;
                    end
                end
                S_RDATA:
                begin
                    if (gap_r != 2'h0)
                        gap_r <= gap_r - 2'h1;
                    // each read strobe yields the next byte
                    else if (len_r == {COL_BITS{1'b0}})
                    begin
                        op_done <= 1'b1;
                        state_r <= S_GAP;
                    end
                    else
                    begin
                        rstart_r <= 1'b1;
                        gap_r <= 2'h0;
                        state_r <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    if (r_sample)
                    begin
                        rd_data <= io_in;
                        rd_valid <= 1'b1;
                    end
                    if (r_done)
                    begin
                        len_r <= len_r - {{(COL_BITS-1){1'b0}}, 1'b1};
                        state_r <= S_RDATA;
                    end
                    else if (op_done)
                        state_r <= S_IDLE;
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end
endmodule

// ### nand_host_assertions.sv
// pin-level checker for the nand host controller
`timescale 1ns/100ps
`include "nand_host_defines.vh"
module nand_host_assertions #(
    parameter ROW_BITS = 15,
    parameter COL_BITS = 10
) (
    // clock and reset
    input logic clk_sys,
    input logic rstn,
    // flash pins
    input logic chip_select_n,
    input logic cmd_latch_sel,
    input logic addr_latch_sel,
    input logic write_strobe_n,
    input logic data_out_strobe_n,
    input logic program_lock_n,
    input logic [7:0] io_out,
    input logic io_oe_n
);
    // ****************************************
    // address cycle counter
    // ****************************************
    logic [1:0] addr_cnt_r;
    logic [1:0] addr_cnt_nxt;
    logic strobe_r;
    always @*
    begin
        addr_cnt_nxt = addr_cnt_r;
        if (cmd_latch_sel)
            addr_cnt_nxt = 2'h0;
        else if (addr_latch_sel && write_strobe_n && !strobe_r && addr_cnt_r != 2'h3)
            addr_cnt_nxt = addr_cnt_r + 2'h1;
    end
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            addr_cnt_r <= 2'h0;
            strobe_r <= 1'b1;
        end
        else
        begin
            addr_cnt_r <= addr_cnt_nxt;
            strobe_r <= write_strobe_n;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence cmd_rise;
        cmd_latch_sel && $rose(write_strobe_n);
    endsequence
    sequence addr_rise;
        addr_latch_sel && $rose(write_strobe_n);
    endsequence
    strobe_needs_select_a: assert property (!write_strobe_n |-> !chip_select_n) else $error("strobe unselected");
    drive_on_write_a: assert property (!write_strobe_n |-> !io_oe_n) else $error("lines not driven");
    latch_exclusive_a: assert property (!(cmd_latch_sel && addr_latch_sel)) else $error("both latches");
    stable_byte_a: assert property ($rose(write_strobe_n) |-> $stable(io_out) && $stable(cmd_latch_sel))
        else $error("byte moved at latch edge");
    strobe_low_width_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4])
        else $error("write strobe low too short");
    read_released_a: assert property (!data_out_strobe_n |-> io_oe_n && !chip_select_n && !cmd_latch_sel)
        else $error("read strobe with host driving");
    defined_cmd_a: assert property (cmd_rise |-> io_out inside {`CMD_READ_LO, `CMD_READ_HI, `CMD_READ_SPARE,
        `CMD_READ_ID, `CMD_RESET, `CMD_PROG_SETUP, `CMD_PROG_GO, `CMD_ERASE_SETUP, `CMD_ERASE_GO, `CMD_STATUS})
        else $error("undefined command");
    lock_on_confirm_a: assert property (cmd_rise ##0 (io_out == `CMD_PROG_GO || io_out == `CMD_ERASE_GO)
        |-> program_lock_n) else $error("confirm with lock low");
    addr_limit_a: assert property (addr_rise |-> addr_cnt_r != 2'h3) else $error("extra address cycle");
    third_bit7_a: assert property (addr_rise ##0 (addr_cnt_r == 2'h2) |-> !io_out[7]) else $error("bit 7 set");
endmodule
bind nand_host nand_host_assertions #(.ROW_BITS(ROW_BITS), .COL_BITS(COL_BITS)) u_nand_host_assertions (.clk_sys,
    .rstn, .chip_select_n, .cmd_latch_sel, .addr_latch_sel, .write_strobe_n, .data_out_strobe_n, .program_lock_n,
    .io_out, .io_oe_n);

// ### flash_model.sv
// behavioural small-page flash answering the host pins
`timescale 1ns/100ps
`include "nand_host_defines.vh"
module flash_model #(
    parameter BUSY_NS = 2000,
    parameter MAKER_CODE = 8'h5A, // arbitrary value
    parameter STATUS_READY = 8'hC0
) (
    // selects and strobes
    input logic chip_select_n,
    input logic cmd_latch_sel,
    input logic addr_latch_sel,
    input logic write_strobe_n,
    input logic data_out_strobe_n,
    // static controls
    input logic program_lock_n,
    input logic spare_area_skip,
    // shared lines and ready
    input logic [7:0] io_out,
    output logic [7:0] io_q,
    output logic ready_busy_n
);
    logic [7:0] cmd_log[$];
    logic [7:0] addr_log[$];
    logic [7:0] data_log[$];
    logic [7:0] cmd_r = 8'hFF;
    logic [7:0] a0_r = 8'h00;
    logic [7:0] drv_r = 8'h00;
    logic [9:0] col_r = 10'h000;
    logic half_r = 1'b0;
    logic busy_r = 1'b0;
    int acnt = 0;
    int ign_cnt = 0;
    event kick;
    assign ready_busy_n = !busy_r;
    // released lines show the inverse of the last byte
    assign io_q = (!chip_select_n && !data_out_strobe_n) ? drv_r : ~drv_r;
    // busy runs out whatever the selects do
    always @(kick)
    begin
        busy_r = 1'b1;
        #(BUSY_NS);
        busy_r = 1'b0;
    end
    always @(posedge write_strobe_n)
    begin
        if (!chip_select_n && cmd_latch_sel)
        begin
            if (busy_r && io_out != `CMD_RESET && io_out != `CMD_STATUS)
                ign_cnt++;
            else
            begin
                cmd_log.push_back(io_out);
                cmd_r = io_out;
                acnt = 0;
                if (io_out == `CMD_READ_LO || io_out == `CMD_READ_HI)
                    half_r = io_out[0];
                // confirm works only with lock released
                if ((io_out == `CMD_PROG_GO || io_out == `CMD_ERASE_GO) && program_lock_n)
                    -> kick;
            end
        end
        else if (!chip_select_n && addr_latch_sel)
        begin
            if (acnt < 3)
                addr_log.push_back(io_out);
            if (acnt == 0)
                a0_r = io_out;
            acnt++;
            // start column from command and pointer
            if (acnt == 3 && cmd_r inside {`CMD_READ_LO, `CMD_READ_HI, `CMD_READ_SPARE})
            begin
                col_r = (cmd_r == `CMD_READ_SPARE) ? {6'h20, a0_r[3:0]} : {1'b0, half_r, a0_r};
                half_r = 1'b0;
                -> kick;
            end
        end
        else if (!chip_select_n)
            data_log.push_back(io_out);
    end
    // each read strobe fall gives a byte; page and spare reads also step the column
    always @(negedge data_out_strobe_n)
    begin
        if (cmd_r == `CMD_STATUS)
            drv_r = busy_r ? (STATUS_READY & 8'hBF) : STATUS_READY;
        else if (cmd_r == `CMD_READ_ID)
            drv_r = MAKER_CODE;
        else
        begin
            drv_r = col_r[7:0] ^ {6'h00, col_r[9:8]};
            col_r = (col_r == 10'h20F || (spare_area_skip && col_r == 10'h1FF)) ? 10'h000 : col_r + 10'h001;
        end
    end
endmodule

// ### nand_host_bench.sv
// self-checking bench for the nand host with a flash model
`timescale 1ns/100ps
`include "nand_host_defines.vh"
module nand_host_bench;
    typedef struct {logic [2:0] op; logic [14:0] row; logic [7:0] col; logic [9:0] len;
        logic [7:0] c1; logic [7:0] c2; int na; logic [9:0] base;} row_t;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic [14:0] req_row = 15'h0000;
    logic [7:0] req_col = 8'h00;
    logic [9:0] req_len = 10'h000;
    logic [7:0] wr_data = 8'h30;
    wire req_ready, wr_take, rd_valid, op_done, chip_select_n, cmd_latch_sel, addr_latch_sel, write_strobe_n;
    wire data_out_strobe_n, program_lock_n, spare_area_skip, io_oe_n, ready_busy_n;
    wire [7:0] rd_data, io_in, io_out, flash_q;
    logic [7:0] rd_q[$];
    row_t rows[9];
    int failures = 0;
    int total_checks = 0;
    // wire level: host drive wins while enabled
    assign io_in = !io_oe_n ? io_out : flash_q;
    nand_host u_nand_host (.clk_sys, .rstn, .req_valid, .req_op, .req_row, .req_col, .req_len, .req_ready, .wr_data,
        .wr_take, .rd_data, .rd_valid, .op_done, .chip_select_n, .cmd_latch_sel, .addr_latch_sel, .write_strobe_n,
        .data_out_strobe_n, .program_lock_n, .spare_area_skip, .io_in, .io_out, .io_oe_n, .ready_busy_n);
    flash_model u_flash_model (.chip_select_n, .cmd_latch_sel, .addr_latch_sel, .write_strobe_n, .data_out_strobe_n,
        .program_lock_n, .spare_area_skip, .io_out, .io_q(flash_q), .ready_busy_n);
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        if (rd_valid === 1'b1)
            rd_q.push_back(rd_data);
        if (wr_take === 1'b1)
            wr_data <= wr_data + 8'h01;
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_rd(input row_t r, input int i);
        logic [9:0] a;
        a = r.base + 10'(i);
        if (r.op == `OP_READ_ID)
            return 8'h5A;
        if (r.op == `OP_STATUS)
            return 8'hC0;
        // spare columns skipped unless spare read
        if (a > 10'h1FF && r.op != `OP_READ_SPARE)
            a = a - 10'h200;
        return a[7:0] ^ {6'h00, a[9:8]};
    endfunction
    task automatic issue(input row_t r);
        int n;
        n = 0;
        @(posedge clk_sys);
        while (req_ready !== 1'b1 && n < 5000)
        begin
            @(posedge clk_sys);
            n++;
        end
        req_valid <= 1'b1;
        req_op <= r.op;
        req_row <= r.row;
        req_col <= r.col;
        req_len <= r.len;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        while (req_ready !== 1'b0 && n < 10000);
        @(posedge clk_sys);
        req_valid <= 1'b0;
    endtask
    task automatic run_row(input row_t r);
        int n;
        logic [7:0] b[3];
        b = '{r.col, r.row[7:0], {1'b0, r.row[14:8]}};
        n = 0;
        u_flash_model.cmd_log.delete();
        u_flash_model.addr_log.delete();
        u_flash_model.data_log.delete();
        rd_q.delete();
        wr_data <= 8'h30;
        issue(r);
        while (op_done !== 1'b1 && n < 20000)
        begin
            @(posedge clk_sys);
            n++;
        end
        check(8'(n / 20000), 8'h00, "completion wait");
        if (r.na >= 2)
            check(8'(n >= 250), 8'h01, "busy wait honoured");
        check(8'(u_flash_model.cmd_log.size()), (r.c2 == 8'h00) ? 8'h01 : 8'h02, "command count");
        check(u_flash_model.cmd_log[0], r.c1, "command code");
        if (r.c2 != 8'h00)
            check(u_flash_model.cmd_log[1], r.c2, "confirm code");
        check(8'(u_flash_model.addr_log.size()), 8'(r.na), "address count");
        for (int i = 0; i < r.na; i++)
            check(u_flash_model.addr_log[i], (r.na == 2) ? b[i + 1] : b[i], "address byte");
        check(8'(u_flash_model.data_log.size()), (r.op == `OP_PROGRAM) ? r.len[7:0] : 8'h00, "data count");
        foreach (u_flash_model.data_log[i])
            check(u_flash_model.data_log[i], 8'h30 + 8'(i), "program byte");
        check(8'(rd_q.size()), (r.op == `OP_PROGRAM) ? 8'h00 : r.len[7:0], "read count");
        foreach (rd_q[i])
            check(rd_q[i], exp_rd(r, i), "read byte");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rows = '{'{`OP_READ_LO, 15'h4ABC, 8'hF8, 10'h00C, `CMD_READ_LO, 8'h00, 3, 10'h0F8},
            '{`OP_READ_HI, 15'h0012, 8'hFA, 10'h008, `CMD_READ_HI, 8'h00, 3, 10'h1FA},
            '{`OP_READ_SPARE, 15'h0007, 8'h0C, 10'h004, `CMD_READ_SPARE, 8'h00, 3, 10'h20C},
            '{`OP_READ_ID, 15'h0000, 8'h00, 10'h001, `CMD_READ_ID, 8'h00, 1, 10'h000},
            '{`OP_STATUS, 15'h0000, 8'h00, 10'h001, `CMD_STATUS, 8'h00, 0, 10'h000},
            '{`OP_RESET, 15'h0000, 8'h00, 10'h000, `CMD_RESET, 8'h00, 0, 10'h000},
            '{`OP_ERASE, 15'h7FE0, 8'h00, 10'h000, `CMD_ERASE_SETUP, `CMD_ERASE_GO, 2, 10'h000},
            '{`OP_PROGRAM, 15'h0101, 8'h03, 10'h005, `CMD_PROG_SETUP, `CMD_PROG_GO, 3, 10'h000},
            '{`OP_READ_LO, 15'h0101, 8'h03, 10'h002, `CMD_READ_LO, 8'h00, 3, 10'h003}};
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (rows[k])
        begin
            run_row(rows[k]);
            $display("test %0d done", k);
        end
        // reset in mid-read: pins must go idle at once
        issue(rows[0]);
        repeat (30) @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check({3'h0, chip_select_n, write_strobe_n, io_oe_n, program_lock_n, req_ready}, 8'h1C, "reset pins");
        @(posedge clk_sys);
        rstn <= 1'b1;
        run_row(rows[4]);
        check(8'(u_flash_model.ign_cnt), 8'h00, "commands while busy");
        $display("test reset done");
        tally_and_finish;
    end
    initial
    begin
        #400000;
        failures++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        tally_and_finish;
    end
endmodule
